// *** bench/hpb_bridge_tb.sv ***
// self-checking bench of the hub-to-pci configuration bridge
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module hpb_bridge_tb;
	// ********
	// signals
	// ********
	logic                  clk, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, int_req = 1'b0, addr_phase = 1'b0;
	logic                  tgt_hit = 1'b0, tgt_ctl = 1'b0, master_ext = 1'b0, ext_devsel = 1'b0, boot_cycle = 1'b0;
	logic                  serr_n = 1'b1, perr_n = 1'b1, int_gnt_n, claim, hub_busy, hub_done, hub_err;
	logic                  upstream_hold, pci_done, serr_out, serr_oe_n, nmi, mgmt_irq;
	logic [7:0]            reg_addr = 8'h00, n_cyc, sec, sub;
	logic [31:0]           reg_wdata = 32'h0, reg_rdata, rd_q, dt;
	logic [5:0]            pci_req_n = 6'h3F, pci_gnt_n, rv;
	logic [4:0]            dv;
	logic [2:0]            fv;
	logic [3:0]            delay = 4'h1;
	logic [7:0]            ectl [4] = '{8'h06, 8'h16, 8'h0A, 8'h02};
	logic [1:0]            eirq [4] = '{2'h2, 2'h1, 2'h2, 2'h0};
	hpb_pkg::hpb_hub_req_s hub_req = '0;
	hpb_pkg::hpb_pci_cyc_s pci_cyc, last_cyc;
	int                    error_cnt = 0, n_tests = 0, cyc = 0, seed, w;

	hpb_bridge dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .pci_req_n(pci_req_n), .pci_gnt_n(pci_gnt_n), .int_req(int_req),
		.int_gnt_n(int_gnt_n), .addr_phase(addr_phase), .tgt_hit(tgt_hit), .tgt_ctl(tgt_ctl),
		.master_ext(master_ext), .ext_devsel(ext_devsel), .boot_cycle(boot_cycle), .claim(claim),
		.hub_req(hub_req), .hub_busy(hub_busy), .hub_done(hub_done), .hub_err(hub_err),
		.upstream_hold(upstream_hold), .pci_cyc(pci_cyc), .pci_done(pci_done), .serr_n(serr_n),
		.serr_out(serr_out), .serr_oe_n(serr_oe_n), .perr_n(perr_n), .nmi(nmi), .system_mgmt_interrupt(mgmt_irq));
	hpb_pci_agent agent_u (.clk(clk), .rst(rst), .pci_cyc(pci_cyc), .delay(delay), .pci_done(pci_done),
		.last_cyc(last_cyc), .n_cyc(n_cyc));

	// free-running clock at 20 MHz
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// hang guard: the whole run needs a few thousand cycles at most
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			complete_run();
		end
	end

	// ********
	// helpers
	// ********
	task automatic complete_run();
		$display("tests %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic ticks(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rd_q = reg_rdata;
	endtask

	// claim moment counted in cycles after the address phase, 0 when never claimed
	task automatic try_claim(input logic hit, ctl, mext, dsel, boot, input int exp_at);
		int at;
		at = 0;
		@(posedge clk);
		addr_phase <= 1'b1;
		tgt_hit <= hit;
		tgt_ctl <= ctl;
		master_ext <= mext;
		boot_cycle <= boot;
		@(posedge clk);
		addr_phase <= 1'b0;
		ext_devsel <= dsel;
		for (int c = 1; c <= 6; c++) begin
			#1 if (claim === 1'b1) at = c;
			@(posedge clk);
		end
		ext_devsel <= 1'b0;
		`CHK(at, exp_at)
	endtask

	// expected forwarded cycle, worked out from the routing rules
	function automatic hpb_pkg::hpb_pci_cyc_s exp_cyc(input logic [7:0] bus, input logic [4:0] dev,
		input logic [2:0] fn, input logic [5:0] rg, input logic w1, input logic [31:0] d);
		exp_cyc = '{valid: 1'b1, cmd: w1 ? hpb_pkg::CMD_CFG_WR : hpb_pkg::CMD_CFG_RD, addr: 32'h0, data: d};
		if (bus == 8'h00)
			exp_cyc.addr = {dev >= 5'h1D ? {hpb_pkg::OWN_DEV_HI, dev[2:0]} : 19'h0, 2'h0, fn, rg, 2'h0};
		else if (bus == sec && w1 && dev == 5'h1F && fn == 3'h7 && rg == 6'h00 && d == 32'h0)
			exp_cyc.cmd = hpb_pkg::CMD_SPECIAL;
		else if (bus == sec)
			exp_cyc.addr = {16'h0001 << dev, 5'h00, fn, rg, 2'h0};
		else
			exp_cyc.addr = {8'h00, bus, dev, fn, rg, 2'h1};
	endfunction

	// one hub request offered for a single cycle, then judged at completion
	task automatic hub(input logic [7:0] bus, input logic [4:0] dev, input logic [2:0] fn, input logic [5:0] rg,
		input logic w1, input logic [31:0] d, input logic lk, input logic io);
		logic [7:0]            n0;
		hpb_pkg::hpb_pci_cyc_s e;
		n0 = n_cyc;
		e = exp_cyc(bus, dev, fn, rg, w1, d);
		@(posedge clk);
		hub_req <= '{valid: 1'b1, is_cfg: !io, is_write: w1, internal_io: io, lock: lk, bus: bus, dev: dev,
			func: fn, reg_num: rg, addr: {8'h00, bus, dev, fn, rg, 2'h1}, data: d};
		@(posedge clk);
		hub_req.valid <= 1'b0;
		#1 w = 0;
		while (hub_done !== 1'b1 && w < 40) begin
			@(posedge clk);
			if (lk && w == 0)
				pci_req_n[0] <= 1'b0;
			#1 w++;
			if (lk && w == 6) begin
				`CHK(upstream_hold, 1'b1)
				`CHK(pci_gnt_n[0], 1'b1)
				`CHK(hub_busy, 1'b1)
			end
		end
		`CHK(hub_done, 1'b1)
		if (io || bus > sub) begin
			`CHK(n_cyc, n0)
			`CHK(hub_err, !io)
		end else begin
			`CHK(last_cyc.cmd, e.cmd)
			if (e.cmd !== hpb_pkg::CMD_SPECIAL)
				`CHK(last_cyc.addr, e.addr)
			if (w1)
				`CHK(last_cyc.data, e.data)
			`CHK(upstream_hold, 1'b0)
			`CHK(hub_err, 1'b0)
		end
		@(posedge clk);
		pci_req_n[0] <= 1'b1;
	endtask

	// ********
	// sequence
	// ********
	initial begin
		seed = 40688;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(hpb_pkg::OFS_STATUS);
		`CHK(rd_q, 32'h0)
		rd(8'h0C);
		`CHK(rd_q, 32'h0)
		wr(hpb_pkg::OFS_CTRL, 32'h0000001F);
		rd(hpb_pkg::OFS_CTRL);
		`CHK(rd_q, 32'h0000001F)
		$display("test registers done");
		// each external master alone, then the internal requester
		for (int k = 0; k < 6; k++) begin
			@(posedge clk);
			pci_req_n[k] <= 1'b0;
			w = 0;
			do begin @(posedge clk); #1 w++; end while (pci_gnt_n[k] !== 1'b0 && w < 10);
			`CHK(w, 3)
			`CHK(pci_gnt_n, ~(6'h01 << k))
			@(posedge clk);
			pci_req_n[k] <= 1'b1;
			ticks(4);
		end
		int_req <= 1'b1;
		ticks(6);
		`CHK({int_gnt_n, pci_gnt_n}, 7'h3F)
		int_req <= 1'b0;
		$display("test arbiter done");
		wr(hpb_pkg::OFS_CTRL, 32'h0);
		try_claim(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2);
		try_claim(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 0);
		try_claim(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 0);
		try_claim(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 2);
		wr(hpb_pkg::OFS_CTRL, 32'h00000001);
		try_claim(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 4);
		try_claim(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 0);
		try_claim(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 0);
		rd(hpb_pkg::OFS_STATUS);
		`CHK(rd_q[2], 1'b1)
		wr(hpb_pkg::OFS_STATUS, 32'h00000004);
		rd(hpb_pkg::OFS_STATUS);
		`CHK(rd_q[2], 1'b0)
		$display("test claim done");
		sec = 8'h01 + 8'($random(seed) & 7);
		sub = sec + 8'h03;
		wr(hpb_pkg::OFS_BUSNUM, {16'h0, sub, sec});
		rd(hpb_pkg::OFS_BUSNUM);
		`CHK(rd_q, {16'h0, sub, sec})
		// two rounds of the routing table with random fields and target speeds
		for (int i = 0; i < 24; i++) begin
			dv = 5'($random(seed));
			fv = 3'($random(seed));
			rv = 6'($random(seed));
			dt = $random(seed);
			delay <= (i % 12 == 11) ? 4'h8 : {2'h0, dt[5:4]};
			case (i % 12)
				0: hub(8'h00, dv % 5'h1D, fv, rv, dt[0], dt, 1'b0, 1'b0);
				1, 2, 3: hub(8'h00, 5'(28 + i % 12), fv, rv, dt[0], dt, 1'b0, 1'b0);
				4: hub(sec, 5'h08, fv, rv, dt[0], dt, 1'b0, 1'b0);
				5: hub(sec, {1'b0, dv[3:0]}, fv, rv, dt[0], dt, 1'b0, 1'b0);
				6: hub(sec, 5'h1F, 3'h7, 6'h00, 1'b1, 32'h0, 1'b0, 1'b0);
				7: hub(sec + 8'h01, dv, fv, rv, dt[0], dt, 1'b0, 1'b0);
				8: hub(sub, dv, fv, rv, dt[0], dt, 1'b0, 1'b0);
				9: hub(sub + 8'h01, dv, fv, rv, dt[0], dt, 1'b0, 1'b0);
				10: hub(8'h00, dv, fv, rv, dt[0], dt, 1'b0, 1'b1);
				default: hub(sec, {1'b0, dv[3:0]}, fv, rv, 1'b0, dt, 1'b1, 1'b0);
			endcase
		end
		$display("test forwarding done");
		// error pins: serr routed to nmi and to smi, perr to nmi and with its enable off
		for (int i = 0; i < 4; i++) begin
			wr(hpb_pkg::OFS_CTRL, {24'h0, ectl[i]});
			if (i < 2)
				serr_n <= 1'b0;
			else
				perr_n <= 1'b0;
			ticks(8);
			`CHK({nmi, mgmt_irq}, eirq[i])
			`CHK(serr_oe_n, 1'b1)
			`CHK(serr_out, 1'b1)
			serr_n <= 1'b1;
			perr_n <= 1'b1;
			wr(hpb_pkg::OFS_CTRL, 32'h0);
			wr(hpb_pkg::OFS_STATUS, 32'h00000007);
			ticks(4);
			`CHK({nmi, mgmt_irq}, 2'h0)
		end
		$display("test errors done");
		@(posedge clk);
		rst <= 1'b1;
		ticks(2);
		rst <= 1'b0;
		rd(hpb_pkg::OFS_BUSNUM);
		`CHK(rd_q, 32'h0)
		$display("test second reset done");
		complete_run();
	end
endmodule

// *** bench/hpb_pci_agent.sv ***
// bench model of the pci bus engine that answers forwarded cycles
`timescale 1ns/1ps
module hpb_pci_agent (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire hpb_pkg::hpb_pci_cyc_s pci_cyc,
	input  wire logic [3:0]            delay,
	output logic                       pci_done,
	output hpb_pkg::hpb_pci_cyc_s      last_cyc,
	output logic [7:0]                 n_cyc
);
	// ********
	// responder
	// ********
	logic [3:0] wait_q;
	logic       busy_q;

	// capture each cycle and finish it after the chosen delay, so slow targets can be mimicked
	// agents modelled here never assert the bus lock line
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wait_q <= 4'h0;
			busy_q <= 1'b0;
			pci_done <= 1'b0;
			last_cyc <= '0;
			n_cyc <= 8'h00;
		end else begin
			pci_done <= 1'b0;
			if (pci_cyc.valid) begin
				last_cyc <= pci_cyc;
				n_cyc <= n_cyc + 8'h01;
				busy_q <= 1'b1;
				wait_q <= delay;
			end else if (busy_q && wait_q != 4'h0) begin
				wait_q <= wait_q - 4'h1;
			end else if (busy_q) begin
				busy_q <= 1'b0;
				pci_done <= 1'b1;
			end
		end
	end
endmodule

// *** verilog/hpb_bridge.sv ***
// hub-to-pci configuration bridge: arbiter, claim decode, config forwarding, error routing
//
// Function
// - arbiter grants six external masters plus internal
// - positive decode claims at medium timing
// - subtractive decode claims late, yields to others
// - boot from card sets status bit 2
// - internal io completes hub side, config forwarded
// - magic config write becomes shutdown special cycle
// - locked slow cycle holds off upstream requests
// - idsel is address line sixteen plus device
// - network function device 8 uses line 24
// - never drive system error, only sample it
// - system error raises nmi or routed smi
// - parity error raises nmi when both enabled; code raises smi instead when route_smi is set
// - only configuration mechanism one supported
// - compare bus against secondary and subordinate
// - type 0 forwarded, device on bits 15:13
// - other devices drive address 31:11 zero
// - configuration cycles are single dword only
// - secondary bus as type 0, beyond as type 1
// - conversion zeros 15:11, keeps 10:1, clears 0
// - internal controllers do no peer traffic
// - all registers reset when core power drops
//
// bus 0 always runs as type 0 unless it is the shutdown write
// an unroutable bus number ends at once with an error pulse
// lock hold withholds external grants only; internal side may move
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module hpb_bridge (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic [7:0]           reg_addr,
	input  wire logic [31:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic [31:0]               reg_rdata,
	input  wire logic [5:0]           pci_req_n,
	output logic [5:0]                pci_gnt_n,
	input  wire logic                 int_req,
	output logic                      int_gnt_n,
	input  wire logic                 addr_phase,
	input  wire logic                 tgt_hit,
	input  wire logic                 tgt_ctl,
	input  wire logic                 master_ext,
	input  wire logic                 ext_devsel,
	input  wire logic                 boot_cycle,
	output logic                      claim,
	input  wire hpb_pkg::hpb_hub_req_s hub_req,
	output logic                      hub_busy,
	output logic                      hub_done,
	output logic                      hub_err,
	output logic                      upstream_hold,
	output hpb_pkg::hpb_pci_cyc_s     pci_cyc,
	input  wire logic                 pci_done,
	input  wire logic                 serr_n,
	output logic                      serr_out,
	output logic                      serr_oe_n,
	input  wire logic                 perr_n,
	output logic                      nmi,
	output logic                      system_mgmt_interrupt
);

	// ****************************************************************
	// state
	// ****************************************************************
	hpb_pkg::hpb_state_s st_q;
	hpb_pkg::hpb_state_s st_d;
	logic                take;
	logic                shut_hit;
	logic [6:0]          arb_req;

	// request taken only while no forwarded cycle is outstanding
	assign take     = hub_req.valid && (st_q.hst == hpb_pkg::HS_IDLE);
	assign shut_hit = hub_req.is_cfg && hub_req.is_write && (hub_req.bus == st_q.sec_bus)
		&& (hub_req.dev == hpb_pkg::SHUT_DEV) && (hub_req.func == hpb_pkg::SHUT_FUNC)
		&& (hub_req.reg_num == hpb_pkg::SHUT_REG) && (hub_req.data == hpb_pkg::SHUTDOWN_MSG);
	// lock hold masks the external masters only; internal side may still move
	assign arb_req  = {int_req, st_q.stat.lock_hold ? 6'h00 : ~st_q.req_s2};

	// ****************************************************************
	// next-state logic
	// ****************************************************************
	always_comb begin
		int   idx;
		logic found;
		logic fwd;
		idx   = 0;
		found = 1'b0;
		fwd   = 1'b0;
		st_d  = st_q;

		// pin synchronisers; only stage two and later feed logic
		st_d.req_s1 = pci_req_n;
		st_d.req_s2 = st_q.req_s1;
		st_d.serr_s = {st_q.serr_s[1:0], serr_n};
		st_d.perr_s = {st_q.perr_s[1:0], perr_n};

		// register writes; serr, perr and boot status bits clear on a one (lock_hold does not), events below win
		st_d.rdata = 32'h0000_0000;
		if (reg_wr) begin
			case (reg_addr)
				hpb_pkg::OFS_CTRL: begin
					st_d.ctrl = hpb_pkg::hpb_ctrl_s'(reg_wdata[$bits(hpb_pkg::hpb_ctrl_s)-1:0]);
				end
				hpb_pkg::OFS_BUSNUM: begin
					st_d.sec_bus = reg_wdata[7:0];
					st_d.sub_bus = reg_wdata[hpb_pkg::BUS_SUB_LSB +: 8];
				end
				hpb_pkg::OFS_STATUS: begin
					st_d.stat.serr = st_q.stat.serr & ~reg_wdata[0];
					st_d.stat.perr = st_q.stat.perr & ~reg_wdata[1];
					st_d.stat.boot = st_q.stat.boot & ~reg_wdata[hpb_pkg::STAT_BOOT_BIT];
				end
				default: begin
				end
			endcase
		end
		// reads answer the next cycle; unmapped offsets read zero
		if (reg_rd) begin
			case (reg_addr)
				hpb_pkg::OFS_CTRL:   st_d.rdata = 32'(st_q.ctrl);
				hpb_pkg::OFS_BUSNUM: st_d.rdata = {16'h0000, st_q.sub_bus, st_q.sec_bus};
				hpb_pkg::OFS_STATUS: st_d.rdata = 32'(st_q.stat);
				default:             st_d.rdata = 32'h0000_0000;
			endcase
		end

		// round robin arbiter: keep owner while it requests, else rotate
		if ((~st_q.gnt_n & arb_req) == 7'h00) begin
			st_d.gnt_n = 7'h7F;
			for (int i = 1; i <= hpb_pkg::NUM_ARB; i++) begin
				idx = (int'(st_q.last) + i) % hpb_pkg::NUM_ARB;
				if (!found && arb_req[idx]) begin
					st_d.gnt_n[idx] = 1'b0;
					st_d.last       = 3'(idx);
					found           = 1'b1;
				end
			end
		end

		// claim timing; flags captured at the address phase
		st_d.claim = 1'b0;
		if (addr_phase) begin
			st_d.pend     = 1'b1;
			st_d.cnt      = 3'h1;
			st_d.pend_sub = st_q.ctrl.sub_mode;
			st_d.pend_ok  = tgt_hit && !(master_ext && tgt_ctl);
			st_d.ext_seen = 1'b0;
			st_d.boot_cyc = boot_cycle;
		end else if (st_q.pend) begin
			st_d.cnt      = st_q.cnt + 3'h1;
			st_d.ext_seen = st_q.ext_seen | ext_devsel;
			if (!st_q.pend_sub && st_q.cnt == hpb_pkg::MED_DEC_CYC - 3'h1) begin
				st_d.claim = st_q.pend_ok;
				st_d.pend  = 1'b0;
			end
			if (st_q.pend_sub && st_q.cnt == hpb_pkg::SUB_DEC_CYC - 3'h1) begin
				// a positive agent that answered first keeps the cycle
				st_d.claim = st_q.pend_ok && !st_q.ext_seen && !ext_devsel;
				st_d.pend  = 1'b0;
				if (st_q.boot_cyc && (st_q.ext_seen || ext_devsel)) begin
					st_d.stat.boot = 1'b1;
				end
			end
		end

		// hub requests: translate, forward or finish locally
		st_d.pci.valid = 1'b0;
		st_d.hub_done  = 1'b0;
		st_d.hub_err   = 1'b0;
		if (take) begin
			st_d.pci.data = hub_req.data;
			if (!hub_req.is_cfg && hub_req.internal_io) begin
				st_d.hub_done = 1'b1;
			end else if (!hub_req.is_cfg) begin
				fwd          = 1'b1;
				st_d.pci.cmd = hub_req.is_write ? hpb_pkg::CMD_IO_WR : hpb_pkg::CMD_IO_RD;
				st_d.pci.addr = hub_req.addr;
			end else begin
				// bus, device, function and register fields come only in mechanism-one form
				st_d.pci.cmd = hub_req.is_write ? hpb_pkg::CMD_CFG_WR : hpb_pkg::CMD_CFG_RD;
				if (hub_req.bus == 8'h00 && !shut_hit) begin
					fwd = 1'b1;
					if (hub_req.dev >= hpb_pkg::OWN_DEV_LO) begin
						st_d.pci.addr = {hpb_pkg::OWN_DEV_HI, hub_req.dev[2:0], 2'b00,
							hub_req.func, hub_req.reg_num, 2'b00};
					end else begin
						st_d.pci.addr = {21'h000000, hub_req.func, hub_req.reg_num, 2'b00};
					end
				end else if (hub_req.bus == st_q.sec_bus) begin
					fwd = 1'b1;
					if (shut_hit) begin
						st_d.pci.cmd  = hpb_pkg::CMD_SPECIAL;
						st_d.pci.addr = 32'h0000_0000;
						st_d.pci.data = hpb_pkg::SHUTDOWN_MSG;
					end else begin
						// one idsel line per device below 16, none above; 8 lands on line 24
						st_d.pci.addr[31:16] = (hub_req.dev < hpb_pkg::IDSEL_LIMIT) ?
							(16'h0001 << hub_req.dev[3:0]) : 16'h0000;
						st_d.pci.addr[15:0] = {5'h00, hub_req.func, hub_req.reg_num, 2'b00};
					end
				end else if (hub_req.bus > st_q.sec_bus && hub_req.bus <= st_q.sub_bus) begin
					fwd           = 1'b1;
					st_d.pci.addr = {8'h00, hub_req.bus, hub_req.dev, hub_req.func,
						hub_req.reg_num, 2'b01};
				end else begin
					st_d.hub_done = 1'b1;
					st_d.hub_err  = 1'b1;
				end
			end
			if (fwd) begin
				st_d.pci.valid      = 1'b1;
				st_d.hst            = hpb_pkg::HS_WAIT;
				st_d.stat.lock_hold = hub_req.lock;
			end
		end else if (st_q.hst == hpb_pkg::HS_WAIT && pci_done) begin
			st_d.hst            = hpb_pkg::HS_IDLE;
			st_d.hub_done       = 1'b1;
			st_d.stat.lock_hold = 1'b0;
		end

		// error sampling on falling edges of the synchronised pins
		if (st_q.serr_s[2:1] == 2'b10 && st_q.ctrl.serr_en) begin
			st_d.stat.serr = 1'b1;
		end
		if (st_q.perr_s[2:1] == 2'b10 && st_q.ctrl.perr_en) begin
			st_d.stat.perr = 1'b1;
		end
		st_d.nmi = st_q.ctrl.nmi_en && !st_q.ctrl.route_smi && (st_q.stat.serr || st_q.stat.perr);
		st_d.smi = st_q.ctrl.nmi_en && st_q.ctrl.route_smi && (st_q.stat.serr || st_q.stat.perr);
		// the error line is only ever an input here
		st_d.serr_oe_n = 1'b1;
	end

	// ****************************************************************
	// state register; reset mirrors loss of core power
	// ****************************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= hpb_pkg::ST_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// outputs taken straight from the state register
	assign reg_rdata             = st_q.rdata;
	assign pci_gnt_n             = st_q.gnt_n[5:0];
	assign int_gnt_n             = st_q.gnt_n[6];
	assign claim                 = st_q.claim;
	assign hub_busy              = st_q.hst == hpb_pkg::HS_WAIT;
	assign hub_done              = st_q.hub_done;
	assign hub_err               = st_q.hub_err;
	assign upstream_hold         = st_q.stat.lock_hold;
	assign pci_cyc               = st_q.pci;
	assign serr_out              = st_q.serr_oe_n; // idle level only; the enable never opens
	assign serr_oe_n             = st_q.serr_oe_n;
	assign nmi                   = st_q.nmi;
	assign system_mgmt_interrupt = st_q.smi;

	// ****************************************************************
	// assertions
	// ****************************************************************
	property p_claim_pos;
		@(posedge clk) disable iff (rst)
		addr_phase && tgt_hit && !master_ext && !st_q.ctrl.sub_mode |=> !claim ##1 claim;
	endproperty
	a_claim_pos: assert property (p_claim_pos) else $error("positive claim not at medium time");

	property p_claim_sub;
		@(posedge clk) disable iff (rst)
		addr_phase && st_q.ctrl.sub_mode |=> !claim [*3];
	endproperty
	a_claim_sub: assert property (p_claim_sub) else $error("subtractive claim came too early");

	property p_serr_in;
		@(posedge clk) disable iff (rst)
		serr_oe_n && $stable(serr_oe_n);
	endproperty
	a_serr_in: assert property (p_serr_in) else $error("system error line driven");

	property p_err_route;
		@(posedge clk) disable iff (rst)
		st_q.ctrl.nmi_en && st_q.stat.serr |=> (nmi != system_mgmt_interrupt) && (nmi == !$past(st_q.ctrl.route_smi));
	endproperty
	a_err_route: assert property (p_err_route) else $error("error interrupt misrouted");

	property p_perr_off;
		@(posedge clk) disable iff (rst)
		!st_q.ctrl.perr_en && !st_q.stat.perr |=> !st_q.stat.perr;
	endproperty
	a_perr_off: assert property (p_perr_off) else $error("parity flagged while disabled");

	property p_shutdown;
		@(posedge clk) disable iff (rst)
		take && shut_hit |=> pci_cyc.valid && pci_cyc.cmd == hpb_pkg::CMD_SPECIAL && pci_cyc.data == 32'h0;
	endproperty
	a_shutdown: assert property (p_shutdown) else $error("shutdown write not converted");

	property p_idsel;
		@(posedge clk) disable iff (rst)
		take && hub_req.is_cfg && !shut_hit && hub_req.bus != 8'h00 && hub_req.bus == st_q.sec_bus
			&& hub_req.dev < 5'h10 |=> pci_cyc.addr[31:16] == (16'h0001 << $past(hub_req.dev[3:0]))
			&& pci_cyc.addr[15:11] == 5'h00 && !pci_cyc.addr[0];
	endproperty
	a_idsel: assert property (p_idsel) else $error("type 1 to type 0 address wrong");

	property p_t0_zero;
		@(posedge clk) disable iff (rst)
		take && hub_req.is_cfg && hub_req.bus == 8'h00 && hub_req.dev < 5'h1D |=> pci_cyc.addr[31:11] == 21'h0;
	endproperty
	a_t0_zero: assert property (p_t0_zero) else $error("type 0 high address not zero");

	property p_int_io;
		@(posedge clk) disable iff (rst)
		take && !hub_req.is_cfg && hub_req.internal_io |=> hub_done && !pci_cyc.valid;
	endproperty
	a_int_io: assert property (p_int_io) else $error("internal io reached the bus");

	// no external grant survives one edge of lock hold
	property p_lock;
		@(posedge clk) disable iff (rst)
		upstream_hold |=> pci_gnt_n == 6'h3F;
	endproperty
	a_lock: assert property (p_lock) else $error("external grant during lock hold");

	// at most one grant out at any time
	property p_arb_onehot;
		@(posedge clk) disable iff (rst)
		$onehot0(~{int_gnt_n, pci_gnt_n});
	endproperty
	a_arb_onehot: assert property (p_arb_onehot) else $error("more than one grant");

	// claim is a single pulse
	property p_claim_one;
		@(posedge clk) disable iff (rst)
		claim |=> !claim;
	endproperty
	a_claim_one: assert property (p_claim_one) else $error("claim longer than one cycle");

	// bus 0 configuration always reaches the bus
	property p_t0_fwd;
		@(posedge clk) disable iff (rst)
		take && hub_req.is_cfg && hub_req.bus == 8'h00 |=> pci_cyc.valid && hub_busy;
	endproperty
	a_t0_fwd: assert property (p_t0_fwd) else $error("type 0 cycle not forwarded");

	// a downstream bus keeps its type 1 form
	property p_t1_fwd;
		@(posedge clk) disable iff (rst)
		take && hub_req.is_cfg && hub_req.bus > st_q.sec_bus && hub_req.bus <= st_q.sub_bus
			|=> pci_cyc.valid && pci_cyc.addr[1:0] == 2'b01 && pci_cyc.addr[23:16] == $past(hub_req.bus);
	endproperty
	a_t1_fwd: assert property (p_t1_fwd) else $error("type 1 cycle malformed");

	// one transfer per forwarded request
	property p_single;
		@(posedge clk) disable iff (rst)
		pci_cyc.valid |=> !pci_cyc.valid;
	endproperty
	a_single: assert property (p_single) else $error("configuration burst issued");

	// completion of a locked cycle frees the upstream side
	property p_hold_free;
		@(posedge clk) disable iff (rst)
		hub_done |-> !upstream_hold;
	endproperty
	a_hold_free: assert property (p_hold_free) else $error("hold kept after completion");

endmodule

// *** verilog/hpb_pkg.sv ***
// constants, field layouts and carrier types of the hub-to-pci configuration bridge
package hpb_pkg;

	// ****************************************************************
	// sizes, counts and register map
	// ****************************************************************
	localparam int        NUM_EXT_MASTERS = 6;
	localparam int        NUM_ARB         = NUM_EXT_MASTERS + 1;
	localparam int        ADDR_W          = 8;
	localparam logic [7:0] OFS_CTRL       = 8'h00;
	localparam logic [7:0] OFS_BUSNUM     = 8'h04;
	localparam logic [7:0] OFS_STATUS     = 8'h08;
	localparam int        STAT_BOOT_BIT   = 2;
	localparam int        BUS_SUB_LSB     = 8;
	// claim moments, counted in clocks from the address phase
	localparam logic [2:0] MED_DEC_CYC    = 3'h2;
	localparam logic [2:0] SUB_DEC_CYC    = 3'h4;

	// ****************************************************************
	// bus commands and fixed address patterns
	// ****************************************************************
	localparam logic [3:0]  CMD_SPECIAL   = 4'h1;
	localparam logic [3:0]  CMD_IO_RD     = 4'h2;
	localparam logic [3:0]  CMD_IO_WR     = 4'h3;
	localparam logic [3:0]  CMD_CFG_RD    = 4'hA;
	localparam logic [3:0]  CMD_CFG_WR    = 4'hB;
	localparam logic [31:0] SHUTDOWN_MSG  = 32'h0000_0000;
	localparam logic [4:0]  SHUT_DEV      = 5'h1F;
	localparam logic [2:0]  SHUT_FUNC     = 3'h7;
	localparam logic [5:0]  SHUT_REG      = 6'h00;
	localparam logic [4:0]  OWN_DEV_LO    = 5'h1D;
	localparam logic [15:0] OWN_DEV_HI    = 16'h0000;
	localparam logic [4:0]  IDSEL_LIMIT   = 5'h10;

	// ****************************************************************
	// carrier types
	// ****************************************************************
	typedef enum logic {HS_IDLE, HS_WAIT} hpb_hub_e;

	typedef struct packed {
		logic route_smi;
		logic perr_en;
		logic serr_en;
		logic nmi_en;
		logic sub_mode;
	} hpb_ctrl_s;

	typedef struct packed {
		logic lock_hold;
		logic boot;
		logic perr;
		logic serr;
	} hpb_stat_s;

	typedef struct packed {
		logic        valid;
		logic        is_cfg;
		logic        is_write;
		logic        internal_io;
		logic        lock;
		logic [7:0]  bus;
		logic [4:0]  dev;
		logic [2:0]  func;
		logic [5:0]  reg_num;
		logic [31:0] addr;
		logic [31:0] data;
	} hpb_hub_req_s;

	typedef struct packed {
		logic        valid;
		logic [3:0]  cmd;
		logic [31:0] addr;
		logic [31:0] data;
	} hpb_pci_cyc_s;

	typedef struct packed {
		logic [31:0]        rdata;
		hpb_ctrl_s          ctrl;
		logic [7:0]         sec_bus;
		logic [7:0]         sub_bus;
		hpb_stat_s          stat;
		logic [5:0]         req_s1;
		logic [5:0]         req_s2;
		logic [2:0]         serr_s;
		logic [2:0]         perr_s;
		logic [6:0]         gnt_n;
		logic [2:0]         last;
		logic [2:0]         cnt;
		logic               pend;
		logic               pend_sub;
		logic               pend_ok;
		logic               ext_seen;
		logic               boot_cyc;
		logic               claim;
		hpb_hub_e           hst;
		hpb_pci_cyc_s       pci;
		logic               hub_done;
		logic               hub_err;
		logic               nmi;
		logic               smi;
		logic               serr_oe_n;
	} hpb_state_s;

	localparam hpb_state_s ST_RST = '{req_s1: 6'h3F, req_s2: 6'h3F, serr_s: 3'h7, perr_s: 3'h7,
		gnt_n: 7'h7F, hst: HS_IDLE, serr_oe_n: 1'b1, default: '0};

endpackage
